// file: logic/bbtd_pkg.sv
// package for the bus breakpoint and trace debugger
package bbtd_pkg;
   // register byte addresses (word-aligned, printed offsets are byte addresses for high/low halves)
   localparam logic [7:0] ADDR_TB_HIGH  = 8'h22;
   localparam logic [7:0] ADDR_TB_LOW   = 8'h23;
   localparam logic [7:0] ADDR_TB_WORD  = 8'h20;  // aligned word holding both halves
   localparam logic [7:0] ADDR_CTRL     = 8'h24;
   localparam logic [7:0] ADDR_CMP_A    = 8'h28;
   localparam logic [7:0] ADDR_CMP_B    = 8'h2c;
   localparam logic [7:0] ADDR_STATUS   = 8'h30;
   localparam logic [7:0] ADDR_PROFILE  = 8'h34;

   // control field positions
   localparam int CTRL_ARM      = 0;
   localparam int CTRL_DBGMODE  = 1;
   localparam int CTRL_BKFULL   = 2;
   localparam int CTRL_BKSWI    = 3;
   localparam int CTRL_BEGIN    = 4;
   localparam int CTRL_TRG_LO   = 8;
   localparam int CTRL_TRG_HI   = 11;
   localparam int CTRL_CAP_LO   = 12;
   localparam int CTRL_CAP_HI   = 13;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // comparator word: address in [15:0], data in [31:16]
   localparam int CMP_ADDR_HI = 15;
   localparam int CMP_DATA_LO = 16;
   localparam int CMP_DATA_HI = 31;

   // trace depth
   localparam int TB_DEPTH = 64;
   localparam int TB_AW    = 6;

   // htrans / hsize codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   typedef enum logic [3:0] {
      TRG_A_ONLY, TRG_A_OR_B, TRG_A_THEN_B, TRG_EV_B, TRG_A_THEN_EV_B,
      TRG_A_AND_B, TRG_A_AND_NOT_B, TRG_INSIDE, TRG_OUTSIDE
   } bbtd_trig_e;

   typedef enum logic [1:0] {
      CAP_NORMAL, CAP_DEDUP, CAP_DETAIL, CAP_PROFILE
   } bbtd_cap_e;

   // one observed processor bus cycle
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [15:0] data;
      logic        fetch;   // program fetch
      logic        free;    // free cycle
      logic        cof;     // fetch following change of flow
      logic        background_instruction;    // background instruction executing
   } bbtd_cpu_s;
endpackage

// file: logic/bbtd_top.sv
// bus breakpoint and trace debugger, ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - control bit picks breakpoint mode or debug mode, never both.
// - dual address breakpoint fires on bus address equal to A or B.
// - full breakpoint fires only when address and data both match.
// - trigger either starts capture or ends capture.
// - triggers A, A|B, A then B, event B, A then event B, and/andnot, ranges.
// - A-and-B and A-and-not-B compare address and data.
// - event B triggers store data of each B event into trace.
// - normal capture stores only change-of-flow program fetches.
// - dedup capture stores change-of-flow fetches, skipping a repeat of the last stored address.
// - detail capture stores address and data except fetch and free cycles.
// - profile mode presents current instruction address for external polling.
// - background instruction never counts as change of flow.
// - byte or misaligned trace read returns zero, pointer unchanged.
// - trace word read while armed returns zero, pointer unchanged.
// - trace data reflects storage directly, no fixed reset value.
// - trace data high half at 0x22, low half at 0x23.
module bbtd_top
   import bbtd_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        CE,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire bbtd_cpu_s   CPU_BUS,
   output logic             BKPT_BACKGROUND,
   output logic             BKPT_SWI,
   output logic             TRIGGERED,
   output logic [15:0]      PROFILE_ADDR
);

   // address match helper, used by several comparators
   function automatic logic cmp_hit(input logic [31:0] cmp, input bbtd_cpu_s c, input logic full);
      cmp_hit = c.valid && (c.addr == cmp[CMP_ADDR_HI:0]) && (!full || c.data == cmp[CMP_DATA_HI:CMP_DATA_LO]);
   endfunction

   logic [31:0]       ctrl_q;
   logic [31:0]       cmp_a_q;
   logic [31:0]       cmp_b_q;
   logic [15:0]       tb_mem [TB_DEPTH];
   logic [TB_AW-1:0]  wr_ptr_q;
   logic [TB_AW-1:0]  rd_ptr_q;
   logic              wrapped_q;
   logic              seen_a_q;
   logic              trig_q;
   logic              armed_q;
   logic [15:0]       last_cof_q;
   logic              last_ok_q;
   logic [15:0]       prof_q;
   logic              bkpt_bg_q;
   logic              bkpt_swi_q;

   // address phase capture
   logic              dp_act_q;
   logic              dp_wr_q;
   logic [7:0]        dp_addr_q;
   logic [2:0]        dp_size_q;

   logic              ap_take;
   assign ap_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
   // slave always answers with zero wait states and OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   bbtd_trig_e trg;
   bbtd_cap_e  cap;
   assign trg = bbtd_trig_e'(ctrl_q[CTRL_TRG_HI:CTRL_TRG_LO]);
   assign cap = bbtd_cap_e'(ctrl_q[CTRL_CAP_HI:CTRL_CAP_LO]);

   logic dbg_mode;
   assign dbg_mode = ctrl_q[CTRL_DBGMODE];

   // data phase bookkeeping
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         dp_act_q  <= 1'b0;
         dp_wr_q   <= 1'b0;
         dp_addr_q <= 8'h00;
         dp_size_q <= 3'h0;
      end
      else if (CE)
      begin
         dp_act_q  <= ap_take;
         dp_wr_q   <= HWRITE;
         dp_addr_q <= HADDR[7:0];
         dp_size_q <= HSIZE;
      end
   end

   // trace read qualifiers: whole aligned word while disarmed
   logic tb_sel;
   logic tb_ok;
   assign tb_sel = dp_act_q && !dp_wr_q && (dp_addr_q[7:2] == ADDR_TB_WORD[7:2]);
   assign tb_ok  = tb_sel && (dp_size_q == HSIZE_WORD) && (dp_addr_q[1:0] == 2'h0) && !armed_q;

   // read mux; halves sit where their byte offsets land in the word
   always_comb
   begin
      HRDATA = 32'h0000_0000;
      if (dp_act_q && !dp_wr_q)
      begin
         case (dp_addr_q[7:2])
            ADDR_TB_WORD[7:2]:
               if (tb_ok)
                  HRDATA = {tb_mem[rd_ptr_q][7:0], tb_mem[rd_ptr_q][15:8], 16'h0000};
            ADDR_CTRL[7:2]:    HRDATA = ctrl_q;
            ADDR_CMP_A[7:2]:   HRDATA = cmp_a_q;
            ADDR_CMP_B[7:2]:   HRDATA = cmp_b_q;
            ADDR_STATUS[7:2]:  HRDATA = {16'h0000, wrapped_q, trig_q, armed_q, 7'h00, wr_ptr_q};
            ADDR_PROFILE[7:2]: HRDATA = {16'h0000, prof_q};
            default:           HRDATA = 32'h0000_0000;
         endcase
      end
   end

   // register writes
   logic wr_ctrl;
   assign wr_ctrl = dp_act_q && dp_wr_q && (dp_addr_q == ADDR_CTRL);

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ctrl_q  <= CTRL_RESET;
         cmp_a_q <= 32'h0000_0000;
         cmp_b_q <= 32'h0000_0000;
      end
      else if (CE)
      begin
         if (wr_ctrl)
            ctrl_q <= HWDATA;
         else if (armed_q && trig_q && !ctrl_q[CTRL_BEGIN])
            ctrl_q[CTRL_ARM] <= 1'b0;                             // end-trigger stops capture
         if (dp_act_q && dp_wr_q && dp_addr_q == ADDR_CMP_A)
            cmp_a_q <= HWDATA;
         if (dp_act_q && dp_wr_q && dp_addr_q == ADDR_CMP_B)
            cmp_b_q <= HWDATA;
      end
   end
   assign armed_q = ctrl_q[CTRL_ARM] && dbg_mode;

   // comparator hits
   logic hit_a;
   logic hit_b;
   logic hit_af;
   logic hit_bf;
   logic in_rng;
   assign hit_a  = cmp_hit(cmp_a_q, CPU_BUS, 1'b0);
   assign hit_b  = cmp_hit(cmp_b_q, CPU_BUS, 1'b0);
   assign hit_af = cmp_hit(cmp_a_q, CPU_BUS, 1'b1);
   assign hit_bf = cmp_hit(cmp_b_q, CPU_BUS, 1'b1);
   assign in_rng = CPU_BUS.valid && CPU_BUS.addr >= cmp_a_q[CMP_ADDR_HI:0]
                   && CPU_BUS.addr <= cmp_b_q[CMP_ADDR_HI:0];

   // breakpoint mode actions, pulse one cycle
   logic bk_hit;
   assign bk_hit = ctrl_q[CTRL_BKFULL] ? (hit_af || hit_bf) : (hit_a || hit_b);

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         bkpt_bg_q  <= 1'b0;
         bkpt_swi_q <= 1'b0;
      end
      else if (CE)
      begin
         bkpt_bg_q  <= !dbg_mode && ctrl_q[CTRL_ARM] && bk_hit && !ctrl_q[CTRL_BKSWI];
         bkpt_swi_q <= !dbg_mode && ctrl_q[CTRL_ARM] && bk_hit && ctrl_q[CTRL_BKSWI];
      end
   end
   assign BKPT_BACKGROUND = bkpt_bg_q;
   assign BKPT_SWI        = bkpt_swi_q;

   // trigger condition
   logic trig_now;
   logic ev_mode;
   assign ev_mode = (trg == TRG_EV_B) || (trg == TRG_A_THEN_EV_B);
   always_comb
   begin
      case (trg)
         TRG_A_ONLY:      trig_now = hit_a;
         TRG_A_OR_B:      trig_now = hit_a || hit_b;
         TRG_A_THEN_B:    trig_now = seen_a_q && hit_b;
         TRG_EV_B:        trig_now = hit_b;
         TRG_A_THEN_EV_B: trig_now = seen_a_q && hit_b;
         TRG_A_AND_B:     trig_now = hit_af && hit_bf;
         TRG_A_AND_NOT_B: trig_now = hit_af && !hit_bf;
         TRG_INSIDE:      trig_now = in_rng;
         TRG_OUTSIDE:     trig_now = CPU_BUS.valid && !in_rng;
         default:         trig_now = 1'b0;
      endcase
   end

   // trigger sequencing state
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         seen_a_q <= 1'b0;
         trig_q   <= 1'b0;
      end
      else if (CE)
      begin
         if (wr_ctrl)
         begin
            seen_a_q <= 1'b0;
            trig_q   <= 1'b0;
         end
         if (armed_q)                                             // a hit in the write cycle still sets
         begin
            if (hit_a)
               seen_a_q <= 1'b1;
            if (trig_now)
               trig_q <= 1'b1;
         end
      end
   end
   assign TRIGGERED = trig_q;

   // capture selection per mode
   logic cof_ok;
   logic store;
   logic [15:0] store_val;
   assign cof_ok = CPU_BUS.valid && CPU_BUS.fetch && CPU_BUS.cof && !CPU_BUS.background_instruction;
   always_comb
   begin
      store     = 1'b0;
      store_val = CPU_BUS.addr;
      if (ev_mode)
      begin
         store     = trig_now;
         store_val = CPU_BUS.data;
      end
      else
      begin
         case (cap)
            CAP_NORMAL: store = cof_ok;
            CAP_DEDUP:  store = cof_ok && !(last_ok_q && last_cof_q == CPU_BUS.addr);
            CAP_DETAIL: store = CPU_BUS.valid && !CPU_BUS.fetch && !CPU_BUS.free;
            default:    store = 1'b0;
         endcase
      end
   end

   // capture window: begin-mode waits for trigger, end-mode runs until it
   logic cap_en;
   assign cap_en = armed_q && (ctrl_q[CTRL_BEGIN] ? (trig_q || trig_now) : 1'b1);

   // detail mode: address now, data in the next entry slot (one write per cycle)
   logic        det_pend_q;
   logic [15:0] det_data_q;

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         wr_ptr_q   <= '0;
         wrapped_q  <= 1'b0;
         last_cof_q <= 16'h0000;
         last_ok_q  <= 1'b0;
         det_pend_q <= 1'b0;
         det_data_q <= 16'h0000;
      end
      else if (CE)
      begin
         if (wr_ctrl && HWDATA[CTRL_ARM])
         begin
            wr_ptr_q   <= '0;
            wrapped_q  <= 1'b0;
            last_ok_q  <= 1'b0;
            det_pend_q <= 1'b0;
         end
         else if (cap_en && (store || det_pend_q))
         begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
            if (&wr_ptr_q)
               wrapped_q <= 1'b1;
            det_pend_q <= store && !ev_mode && cap == CAP_DETAIL && !det_pend_q;
            det_data_q <= CPU_BUS.data;
            if (store && cap == CAP_DEDUP)
            begin
               last_cof_q <= CPU_BUS.addr;
               last_ok_q  <= 1'b1;
            end
         end
      end
   end

   // trace storage, no reset so contents are undefined after reset
   always_ff @(posedge CLK)
   begin
      if (CE && cap_en && (store || det_pend_q))
         tb_mem[wr_ptr_q] <= det_pend_q ? det_data_q : store_val;
   end

   // read pointer advances only on qualified reads, clears on a control write that sets arm
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
         rd_ptr_q <= '0;
      else if (CE)
      begin
         if (wr_ctrl && HWDATA[CTRL_ARM])
            rd_ptr_q <= '0;
         else if (tb_ok)
            rd_ptr_q <= rd_ptr_q + 1'b1;
      end
   end

   // profile address follows each program fetch
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
         prof_q <= 16'h0000;
      else if (CE && dbg_mode && cap == CAP_PROFILE && CPU_BUS.valid && CPU_BUS.fetch)
         prof_q <= CPU_BUS.addr;
   end
   assign PROFILE_ADDR = prof_q;
endmodule
`default_nettype wire

// file: bench/bbtd_props.sv
// assertion checker for the debugger register port and debug outputs
`timescale 1ns/1ps
`default_nettype none
module bbtd_props
   import bbtd_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic        CE,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [2:0]  HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        BKPT_BACKGROUND,
   input wire logic        BKPT_SWI,
   input wire logic        TRIGGERED
);
   logic        ph_q;
   logic        wr_q;
   logic [7:0]  a_q;
   logic [31:0] ctrl_q;
   logic        ctrl_wr;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);

   // address phase record, so control writes can be followed
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ph_q <= 1'b0;
         wr_q <= 1'b0;
         a_q  <= 8'h00;
      end
      else if (CE)
      begin
         ph_q <= HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
         wr_q <= HWRITE;
         a_q  <= HADDR[7:0];
      end
   end

   // shadow of control; arm may drop inside, so only mode bits are trusted
   assign ctrl_wr = ph_q && wr_q && a_q == ADDR_CTRL;
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
         ctrl_q <= CTRL_RESET;
      else if (ctrl_wr && CE)
         ctrl_q <= HWDATA;
   end

   sequence s_narrow_rd;
      HSEL && HREADY && CE && HTRANS == HTRANS_NONSEQ && !HWRITE && HADDR[31:2] == 30'h8
         && (HSIZE != HSIZE_WORD || HADDR[1:0] != 2'h0);
   endsequence
   sequence s_unmapped_rd;
      HSEL && HREADY && CE && HTRANS == HTRANS_NONSEQ && !HWRITE && HADDR[31:8] == 24'h0
         && HADDR[7:0] >= 8'h38;
   endsequence

   a_ready_high: assert property (HREADYOUT) else $error("hreadyout low");
   a_resp_okay: assert property (!HRESP) else $error("hresp not okay");
   a_bg_pulse: assert property (BKPT_BACKGROUND |=> !BKPT_BACKGROUND) else $error("bg not a pulse");
   a_swi_pulse: assert property (BKPT_SWI |=> !BKPT_SWI) else $error("swi not a pulse");
   a_mode_exclusive: assert property (ctrl_q[1] && $past(ctrl_q[1]) |-> !BKPT_BACKGROUND && !BKPT_SWI)
      else $error("breakpoint in debug mode");
   a_swi_select: assert property (BKPT_SWI |-> $past(ctrl_q[3]) && !$past(ctrl_q[1]))
      else $error("swi wrong select");
   a_bg_select: assert property (BKPT_BACKGROUND |-> !$past(ctrl_q[3])) else $error("bg wrong select");
   a_narrow_zero: assert property (s_narrow_rd |=> HRDATA == 32'h0) else $error("narrow read not zero");
   a_unmapped_zero: assert property (s_unmapped_rd |=> HRDATA == 32'h0) else $error("unmapped read not zero");
   a_trig_hold: assert property (TRIGGERED && !ctrl_wr |=> TRIGGERED) else $error("trigger flag lost");
endmodule
bind bbtd_top bbtd_props u_props (.CLK(CLK), .RSTN(RSTN), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .BKPT_BACKGROUND(BKPT_BACKGROUND), .BKPT_SWI(BKPT_SWI), .TRIGGERED(TRIGGERED));
`default_nettype wire

// file: bench/bbtd_cpu_model.sv
// processor bus model feeding observed cycles to the debugger
`timescale 1ns/1ps
`default_nettype none
module bbtd_cpu_model
   import bbtd_pkg::*;
(
   input wire logic      CLK,
   output var bbtd_cpu_s BUS
);
   initial BUS = '0;

   // one bus cycle; flags are {fetch, free, cof, background_instruction}
   task cyc(input logic [15:0] a, input logic [15:0] d, input logic [3:0] f);
      @(posedge CLK);
      BUS <= {1'b1, a, d, f};
      @(posedge CLK);
      BUS <= {1'b0, ~a, ~d, 4'h0}; // idle address and data lines never keep the old value
   endtask
endmodule
`default_nettype wire

// file: bench/bbtd_tb_top.sv
// self-checking testbench for the debugger
`timescale 1ns/1ps
`default_nettype none
module bbtd_tb_top;
   import bbtd_pkg::*;
   logic        CLK, RSTN, CE, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
   logic        BKPT_BACKGROUND, BKPT_SWI, TRIGGERED;
   logic [31:0] HADDR, HWDATA, HRDATA, r;
   logic [1:0]  HTRANS;
   logic [2:0]  HSIZE;
   logic [15:0] PROFILE_ADDR;
   bbtd_cpu_s   CPU_BUS;
   int          fails, compares, cyc_n, n_bg, n_swi;
   localparam logic [3:0] F_FET = 4'h8, F_COF = 4'ha, F_FREE = 4'h4, F_BG = 4'hb, F_DAT = 4'h0;
   // trigger table: type, first cycle, second cycle, expected flag
   logic [36:0] trg_tbl [11] = '{{4'h0, 16'h1000, 16'h0100, 1'b1}, {4'h1, 16'h1800, 16'h0100, 1'b1},
      {4'h2, 16'h1800, 16'h1000, 1'b0}, {4'h2, 16'h1000, 16'h1800, 1'b1}, {4'h3, 16'h1800, 16'h0100, 1'b1},
      {4'h4, 16'h1000, 16'h1800, 1'b1}, {4'h5, 16'h1000, 16'h1800, 1'b0}, {4'h6, 16'h0100, 16'h0200, 1'b0},
      {4'h7, 16'h1800, 16'h0100, 1'b1}, {4'h8, 16'h1800, 16'h1000, 1'b0}, {4'h8, 16'h1801, 16'h0100, 1'b1}};

   assign HREADY = HREADYOUT;
   bbtd_top u_dut (.CLK(CLK), .RSTN(RSTN), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CPU_BUS(CPU_BUS), .BKPT_BACKGROUND(BKPT_BACKGROUND),
      .BKPT_SWI(BKPT_SWI), .TRIGGERED(TRIGGERED), .PROFILE_ADDR(PROFILE_ADDR));
   bbtd_cpu_model u_cpu (.CLK(CLK), .BUS(CPU_BUS));

   initial
   begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   // pulse counters and hang guard
   always @(posedge CLK)
   begin
      cyc_n++;
      if (BKPT_BACKGROUND === 1'b1) n_bg++;
      if (BKPT_SWI === 1'b1) n_swi++;
      if (cyc_n == 6000)
      begin
         fails++;
         tally_and_finish();
      end
   end

   task chk(input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %0t exp %h got %h", $time, exp, got);
      end
   endtask

   // one ahb transfer, entered and left just after a rising edge
   task xfer(input logic w, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] d);
      HSEL <= 1'b1;
      HADDR <= a;
      HTRANS <= HTRANS_NONSEQ;
      HWRITE <= w;
      HSIZE <= sz;
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      HTRANS <= 2'h0;
      HSEL <= 1'b0;
      HWDATA <= d;
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      r = HRDATA;
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, HSIZE_WORD, d);
   endtask

   task rd_chk(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] exp);
      xfer(1'b0, a, sz, 32'h0);
      chk(exp, r);
   endtask

   // disarm, then two trace words; low half lands in the top byte
   task rd2(input logic [31:0] c, input logic [15:0] a, input logic [15:0] b);
      wr({24'h0, ADDR_CTRL}, c);
      rd_chk({24'h0, ADDR_TB_WORD}, HSIZE_WORD, {a[7:0], a[15:8], 16'h0});
      rd_chk({24'h0, ADDR_TB_WORD}, HSIZE_WORD, {b[7:0], b[15:8], 16'h0});
   endtask

   task tally_and_finish;
      if (fails == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      RSTN = 1'b0; CE = 1'b1; HSEL = 1'b0; HADDR = '0; HTRANS = '0; HWRITE = 1'b0; HSIZE = '0; HWDATA = '0;
      fails = 0; compares = 0; cyc_n = 0; n_bg = 0; n_swi = 0;
      repeat (5) @(posedge CLK);
      RSTN <= 1'b1;
      @(posedge CLK);
      rd_chk(32'h40, HSIZE_WORD, 32'h0);
      wr(32'h2c, 32'h0000_5678);
      wr(32'h28, 32'h0000_1234);
      wr(32'h24, 32'h9);
      u_cpu.cyc(16'h5678, 16'h0, F_FET);
      u_cpu.cyc(16'h4321, 16'h0, F_FET);
      repeat (4) @(posedge CLK);
      chk(32'h1, 32'(n_swi));
      wr(32'h24, 32'h1);
      u_cpu.cyc(16'h1234, 16'h0, F_FET);
      repeat (4) @(posedge CLK);
      chk(32'h1, 32'(n_bg));
      // clock enable low: the same hit must be ignored
      CE <= 1'b0;
      u_cpu.cyc(16'h1234, 16'h0, F_FET);
      CE <= 1'b1;
      repeat (4) @(posedge CLK);
      chk(32'h1, 32'(n_bg));
      wr(32'h28, 32'hbeef_1234);
      wr(32'h24, 32'h5);
      u_cpu.cyc(16'h1234, 16'h0, F_DAT);
      u_cpu.cyc(16'h1234, 16'hbeef, F_DAT);
      repeat (4) @(posedge CLK);
      chk(32'h2, 32'(n_bg));
      // normal capture from trigger on A, background_instruction fetch must be skipped
      wr(32'h28, 32'h0000_1000);
      wr(32'h24, 32'h13);
      u_cpu.cyc(16'h1000, 16'h0, F_FET);
      u_cpu.cyc(16'h2000, 16'h0, F_COF);
      u_cpu.cyc(16'h2002, 16'h0, F_FET);
      u_cpu.cyc(16'h3000, 16'h0, F_BG);
      u_cpu.cyc(16'h4000, 16'h0, F_COF);
      repeat (4) @(posedge CLK);
      chk(32'h2, 32'(n_bg));
      rd_chk(32'h20, HSIZE_WORD, 32'h0);
      wr(32'h24, 32'h12);
      rd_chk(32'h22, 3'h0, 32'h0);
      rd_chk(32'h22, HSIZE_WORD, 32'h0);
      rd2(32'h12, 16'h2000, 16'h4000);
      wr(32'h24, 32'h1013);
      u_cpu.cyc(16'h1000, 16'h0, F_FET);
      u_cpu.cyc(16'h2000, 16'h0, F_COF);
      u_cpu.cyc(16'h2000, 16'h0, F_COF);
      u_cpu.cyc(16'h5000, 16'h0, F_COF);
      rd2(32'h1012, 16'h2000, 16'h5000);
      wr(32'h24, 32'h2013);
      u_cpu.cyc(16'h1000, 16'h0, F_FET);
      u_cpu.cyc(16'h2000, 16'h0, F_COF);
      u_cpu.cyc(16'h0900, 16'h1111, F_FREE);
      u_cpu.cyc(16'h0800, 16'habcd, F_DAT);
      rd2(32'h2012, 16'h0800, 16'habcd);
      wr(32'h2c, 32'h0000_1800);
      wr(32'h24, 32'h0313);
      u_cpu.cyc(16'h1800, 16'h5a5a, F_DAT);
      u_cpu.cyc(16'h1800, 16'h0f0f, F_DAT);
      rd2(32'h0312, 16'h5a5a, 16'h0f0f);
      wr(32'h24, 32'h3003);
      u_cpu.cyc(16'h2468, 16'h0, F_FET);
      repeat (2) @(posedge CLK);
      chk(32'h2468, {16'h0, PROFILE_ADDR});
      // every trigger kind; bus data is zero like the compare data fields
      for (int i = 0; i < 11; i++)
      begin
         wr(32'h24, {20'h0, trg_tbl[i][36:33], 8'h03});
         u_cpu.cyc(trg_tbl[i][32:17], 16'h0, F_DAT);
         u_cpu.cyc(trg_tbl[i][16:1], 16'h0, F_DAT);
         repeat (3) @(posedge CLK);
         chk({31'h0, trg_tbl[i][0]}, {31'h0, TRIGGERED});
      end
      // a-and-not-b needs the data of a to match as well
      wr(32'h28, 32'hbeef_1000);
      wr(32'h24, 32'h0603);
      u_cpu.cyc(16'h1000, 16'h0, F_DAT);
      repeat (3) @(posedge CLK);
      chk(32'h0, {31'h0, TRIGGERED});
      u_cpu.cyc(16'h1000, 16'hbeef, F_DAT);
      repeat (3) @(posedge CLK);
      chk(32'h1, {31'h0, TRIGGERED});
      tally_and_finish();
   end
endmodule
`default_nettype wire
